// File: design/agdl_band.sv
// demagnetization-time classifier: band step and sleep thresholds
`timescale 1ns/1ps
`default_nettype none
`include "agdl_params.svh"

module agdl_band (
    input  wire logic [11:0] demag_cyc_in,    // measured demagnetization cycles
    input  wire logic [9:0]  min_on_cyc_in,   // programmed minimum on-time
    output logic      [3:0]  meas_step_out,   // band index, 0 means step 1
    output logic             sleep_in_out,    // short enough to enter sleep
    output logic             sleep_out_out    // long enough to leave sleep
);

    // ------------------------------------------------------------------
    // boundary test
    // ------------------------------------------------------------------
    // 6*td >= 6*offset + tmin*(n+6), kept integral to avoid a divider
    function automatic logic reached(input logic [11:0] td,
                                     input logic [9:0]  tmin,
                                     input logic [4:0]  n);
        logic [17:0] lhs;
        logic [17:0] rhs;
        lhs = 18'(td) * 18'h6;
        rhs = 18'(`AGDL_TD_OFS_CYC) * 18'h6 + 18'(tmin) * 18'(n + 5'h6);
        return lhs >= rhs;
    endfunction

    // ------------------------------------------------------------------
    // count boundaries passed
    // ------------------------------------------------------------------
    logic [4:0] passed;   // boundaries 1..16 reached

    always_comb begin
        passed = 5'h0;
        for (int n = 1; n <= `AGDL_STEPS; n++) begin
            if (reached(demag_cyc_in, min_on_cyc_in, 5'(n))) begin
                passed = passed + 5'h1;
            end
        end
    end

    // longer demagnetization gives a higher step [RULE2] [RULE3]
    assign meas_step_out = (passed == 5'h0) ? 4'h0 : 4'(passed - 5'h1);

    // sleep in at tmin + offset, out at 1.2 tmin + offset [RULE9]
    assign sleep_in_out  = (13'(demag_cyc_in) <=
                            13'(min_on_cyc_in) + 13'(`AGDL_TD_OFS_CYC));
    assign sleep_out_out = (16'(demag_cyc_in) * 16'h5 >=
                            16'(min_on_cyc_in) * 16'h6 + 16'(5 * `AGDL_TD_OFS_CYC));

endmodule
`default_nettype wire

// File: design/agdl_top.sv
// adaptive gate-drive level control with pulse limits and low-power modes
//
// How it works
// [RULE1] pulse always ends by maximum on-time
// [RULE2] sixteen level steps tied to demagnetization bands
// [RULE3] band n edge: offset plus tmin*(n+6)/6
// [RULE4] step moves after 32 consecutive agreeing cycles
// [RULE5] adaptation enable and disable with hysteresis
// [RULE6] with adaptation enabled, low supply caps level at supply or less
// [RULE7] burst suspends adaptation, resumes at top level
// [RULE8] sleep exit restarts at low level, climbs
// [RULE9] sleep entry and exit thresholds, one cycle
// [RULE10] after stop: skip one, then minimum pulse
// [RULE11] level index saturates at both ends
`timescale 1ns/1ps
`default_nettype none
`include "agdl_params.svh"

module agdl_top (
    input  wire logic              clk_in,            // 40 MHz clock
    input  wire logic              sys_rst_in,        // sync reset, high
    input  wire logic              drain_sense_in,    // high: drain above threshold
    input  wire logic              supply_above_en_in, // above enable threshold
    input  wire logic              supply_below_dis_in, // below disable threshold
    input  wire logic              supply_low_in,     // supply too low for full level
    input  wire logic              aux_supply_pin_in, // auxiliary supply in use
    input  wire logic [9:0]        min_on_cyc_in,     // programmed minimum on-time
    output logic                   gate_drive_out,    // gate drive pulse
    output logic      [3:0]        drive_level_step_out, // level index, 0 = step 1
    output agdl_pkg::agdl_limit_e  drive_limit_out,   // low-supply cap select
    output logic                   sleep_mode_out,    // sleep state
    output logic                   burst_mode_out     // switching stop seen
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pin_s1;     // first stage, read by second only
    logic [4:0] pin_s2;     // second stage
    logic [4:0] pin_s3;     // third stage
    logic [4:0] pin_q;      // filtered level
    wire  [4:0] pins_raw = {aux_supply_pin_in, supply_low_in, supply_below_dis_in,
                            supply_above_en_in, drain_sense_in};
    wire  [4:0] pin_agree = ~(pin_s2 ^ pin_s3); // stages two and three match

    // three stages, a change counts when stages two and three agree
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_s1 <= 5'h01;
            pin_s2 <= 5'h01;
            pin_s3 <= 5'h01;
            pin_q  <= 5'h01;
        end else begin
            pin_s1 <= pins_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q  <= (pin_s3 & pin_agree) | (pin_q & ~pin_agree);
        end
    end

    // ------------------------------------------------------------------
    // named levels and edges
    // ------------------------------------------------------------------
    logic  drain_prev;                        // last drain level
    wire   drain_hi  = pin_q[0];              // drain above threshold
    wire   en_hit    = pin_q[1];              // supply above enable
    wire   dis_hit   = pin_q[2];              // supply below disable
    wire   sup_low   = pin_q[3];              // supply short of full level
    wire   aux_used  = pin_q[4];              // auxiliary supply present
    wire   fall      = drain_prev & ~drain_hi; // conduction starts
    wire   cyc_end   = ~drain_prev & drain_hi; // demagnetization ends

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    agdl_pkg::agdl_state_e state;             // operating state
    agdl_pkg::agdl_state_e next_state;        // next operating state
    logic [11:0] demag_cnt;                   // cycles since conduction start
    logic [11:0] stop_cnt;                    // cycles with drain high
    logic [3:0]  idx;                         // adapted level index
    logic [3:0]  next_idx;                    // next level index
    logic [4:0]  up_run;                      // consecutive higher cycles
    logic [4:0]  dn_run;                      // consecutive lower cycles
    logic        adapt_en;                    // supply allows adaptation
    logic        gate;                        // gate drive flop
    logic        burst;                       // switching stopped
    logic [3:0]  meas_step;                   // band of the last cycle
    logic        sleep_in_hit;                // short cycle
    logic        sleep_out_hit;               // long cycle

    agdl_band u_band (
        .demag_cyc_in  (demag_cnt),
        .min_on_cyc_in (min_on_cyc_in),
        .meas_step_out (meas_step),
        .sleep_in_out  (sleep_in_hit),
        .sleep_out_out (sleep_out_hit)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire        adapting  = adapt_en & ~burst & (state == agdl_pkg::ST_RUN); // [RULE7]
    wire        step_up   = cyc_end & adapting & (meas_step > idx);
    wire        step_dn   = cyc_end & adapting & (meas_step < idx);
    wire        up_done   = step_up & (up_run == 5'(`AGDL_CONFIRM_RUNS - 1)); // [RULE4]
    wire        dn_done   = step_dn & (dn_run == 5'(`AGDL_CONFIRM_RUNS - 1)); // [RULE4]
    wire        stop_hit  = drain_hi & (stop_cnt == 12'(`AGDL_TSTOP_CYC - 1));
    wire [11:0] on_limit  = (state == agdl_pkg::ST_MINON) ? 12'(min_on_cyc_in)
                            : 12'(`AGDL_TON_MAX_CYC);
    wire        drive_ok  = (state == agdl_pkg::ST_RUN) | (state == agdl_pkg::ST_MINON);
    // pulse ends at the drain rise or at the on-time limit [RULE1] [RULE10]
    wire        next_gate = fall ? drive_ok
                            : (gate & ~cyc_end & (demag_cnt < on_limit));
    wire        next_en   = dis_hit ? 1'b0 : (en_hit ? 1'b1 : adapt_en); // [RULE5]

    // state and index selection
    always_comb begin
        next_state = state;
        next_idx   = idx;
        if (stop_hit && !burst && state != agdl_pkg::ST_SLEEP) begin
            next_state = agdl_pkg::ST_SKIP;                     // [RULE10]
            next_idx   = `AGDL_LEVEL_TOP;                       // [RULE7]
        end else if (cyc_end) begin
            unique case (state)
                agdl_pkg::ST_SLEEP: begin
                    if (sleep_out_hit) begin
                        next_state = agdl_pkg::ST_RUN;         // [RULE9]
                        next_idx   = `AGDL_LEVEL_LOW;          // [RULE8]
                    end
                end
                agdl_pkg::ST_RUN: begin
                    if (sleep_in_hit) begin
                        next_state = agdl_pkg::ST_SLEEP;       // [RULE9]
                    end else if (up_done && idx != `AGDL_LEVEL_TOP) begin
                        next_idx = idx + 4'h1;                 // [RULE4] [RULE11]
                    end else if (dn_done && idx != `AGDL_LEVEL_LOW) begin
                        next_idx = idx - 4'h1;                 // [RULE4] [RULE11]
                    end
                end
                agdl_pkg::ST_SKIP: begin
                    if (!burst) begin
                        next_state = agdl_pkg::ST_MINON;       // [RULE10]
                    end
                end
                agdl_pkg::ST_MINON: begin
                    next_state = agdl_pkg::ST_RUN;
                    next_idx   = `AGDL_LEVEL_TOP;              // [RULE7]
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // counters and mode flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            drain_prev <= 1'b1;
            demag_cnt  <= 12'h000;
            stop_cnt   <= 12'h000;
            burst      <= 1'b0;
        end else begin
            drain_prev <= drain_hi;
            // measure conduction, saturating
            if (fall) begin
                demag_cnt <= 12'h001;
            end else if (!drain_hi && demag_cnt != 12'hfff) begin
                demag_cnt <= demag_cnt + 12'h001;
            end
            // time the drain-high gap
            if (!drain_hi) begin
                stop_cnt <= 12'h000;
            end else if (!stop_hit) begin
                stop_cnt <= stop_cnt + 12'h001;
            end
            // burst from a long stop until switching resumes [RULE7]
            if (fall) begin
                burst <= 1'b0;
            end else if (stop_hit) begin
                burst <= 1'b1;
            end
        end
    end

    // confirmation runs, broken by any disagreeing cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            up_run <= 5'h00;
            dn_run <= 5'h00;
        end else if (cyc_end) begin
            up_run <= (step_up && !up_done) ? up_run + 5'h01 : 5'h00; // [RULE4]
            dn_run <= (step_dn && !dn_done) ? dn_run + 5'h01 : 5'h00; // [RULE4]
        end
    end

    // state, level and outputs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state                <= agdl_pkg::ST_SLEEP;
            idx                  <= `AGDL_LEVEL_LOW;
            adapt_en             <= 1'b0;
            gate                 <= 1'b0;
            drive_level_step_out <= `AGDL_LEVEL_TOP;
            drive_limit_out      <= agdl_pkg::LIM_NONE;
            sleep_mode_out       <= 1'b1;
            burst_mode_out       <= 1'b0;
        end else begin
            state          <= next_state;
            idx            <= next_idx;
            adapt_en       <= next_en;
            gate           <= next_gate;
            sleep_mode_out <= (next_state == agdl_pkg::ST_SLEEP);
            burst_mode_out <= (burst | stop_hit) & ~fall;
            // modulation off: full level [RULE5]
            drive_level_step_out <= next_en ? next_idx : `AGDL_LEVEL_TOP;
            // cap the level on a weak supply [RULE6]
            if (next_en && sup_low) begin
                drive_limit_out <= aux_used ? agdl_pkg::LIM_SUPPLY : agdl_pkg::LIM_DROP;
            end else begin
                drive_limit_out <= agdl_pkg::LIM_NONE;
            end
        end
    end

    assign gate_drive_out = gate;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence seq_skip_cycle;
        (state == agdl_pkg::ST_SKIP) && cyc_end && !burst;
    endsequence
    sequence seq_minon_end;
        (state == agdl_pkg::ST_MINON) && cyc_end && !stop_hit;
    endsequence

    chk_max_on_time: assert property ( // [RULE1]
        gate |-> demag_cnt <= 12'(`AGDL_TON_MAX_CYC))
        else $error("gate pulse exceeds maximum on-time");
    chk_step_up_run: assert property ( // [RULE4]
        (up_done && idx != `AGDL_LEVEL_TOP && state == agdl_pkg::ST_RUN && !sleep_in_hit)
        |=> idx == $past(idx) + 4'h1)
        else $error("level did not rise after confirmed run");
    chk_step_hold: assert property ( // [RULE4]
        (state == agdl_pkg::ST_RUN && !cyc_end && !stop_hit) |=> $stable(idx))
        else $error("level moved outside a cycle end");
    chk_top_saturate: assert property ( // [RULE11]
        (adapting && idx == `AGDL_LEVEL_TOP && !dn_done) |=> idx == `AGDL_LEVEL_TOP)
        else $error("level wrapped past the top step");
    chk_enable_hyst: assert property ( // [RULE5]
        dis_hit |=> !adapt_en && drive_level_step_out == `AGDL_LEVEL_TOP)
        else $error("adaptation stayed on below disable threshold");
    chk_low_supply_cap: assert property ( // [RULE6]
        (next_en && sup_low && !aux_used) |=> drive_limit_out == agdl_pkg::LIM_DROP)
        else $error("low supply cap not applied");
    chk_stop_restart: assert property ( // [RULE7] [RULE10]
        (stop_hit && !burst && state != agdl_pkg::ST_SLEEP)
        |=> state == agdl_pkg::ST_SKIP && idx == `AGDL_LEVEL_TOP)
        else $error("switching stop did not reset level to top");
    chk_skip_to_minon: assert property ( // [RULE10]
        seq_skip_cycle |=> state == agdl_pkg::ST_MINON)
        else $error("skipped cycle not followed by minimum pulse cycle");
    chk_burst_restart: assert property ( // [RULE7] [RULE10]
        seq_minon_end |=> idx == `AGDL_LEVEL_TOP && state == agdl_pkg::ST_RUN)
        else $error("burst resume did not start at top level");
    chk_skip_no_drive: assert property ( // [RULE10]
        (state == agdl_pkg::ST_SKIP) |-> ##1 (!$rose(gate)))
        else $error("gate driven in skipped cycle");
    chk_min_pulse: assert property ( // [RULE10]
        (gate && state == agdl_pkg::ST_MINON) |-> demag_cnt <= 12'(min_on_cyc_in))
        else $error("minimum pulse too long");
    chk_sleep_exit: assert property ( // [RULE8] [RULE9]
        (state == agdl_pkg::ST_SLEEP && cyc_end && sleep_out_hit && !stop_hit)
        |=> state == agdl_pkg::ST_RUN && idx == `AGDL_LEVEL_LOW && !sleep_mode_out)
        else $error("sleep exit not taken in one cycle");

endmodule
`default_nettype wire

// File: inc/agdl_params.svh
// timing counts and fixed levels of the adaptive gate-drive level block
`ifndef AGDL_PARAMS_SVH
`define AGDL_PARAMS_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define AGDL_CLK_NS        25

// ----------------------------------------------------------------------
// times in ns and their cycle counts
// ----------------------------------------------------------------------
// fixed offset of every demagnetization boundary (least time, round up)
`define AGDL_TD_OFS_NS     300
`define AGDL_TD_OFS_CYC    ((`AGDL_TD_OFS_NS + `AGDL_CLK_NS - 1) / `AGDL_CLK_NS)
// longest drive pulse (longest time, round down)
`define AGDL_TON_MAX_NS    20000
`define AGDL_TON_MAX_CYC   (`AGDL_TON_MAX_NS / `AGDL_CLK_NS)
// drain-high time that marks a primary switching stop (least time, round up)
`define AGDL_TSTOP_NS      40000
`define AGDL_TSTOP_CYC     ((`AGDL_TSTOP_NS + `AGDL_CLK_NS - 1) / `AGDL_CLK_NS)

// ----------------------------------------------------------------------
// level stepping
// ----------------------------------------------------------------------
`define AGDL_STEPS         16
`define AGDL_CONFIRM_RUNS  32
`define AGDL_LEVEL_TOP     4'hf
`define AGDL_LEVEL_LOW     4'h0

`endif

// File: inc/agdl_pkg.sv
// types shared by the adaptive gate-drive level block
package agdl_pkg;

    // ------------------------------------------------------------------
    // operating state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,   // no drive, waiting for long demagnetization
        ST_RUN   = 2'b01,   // normal drive with level adaptation
        ST_SKIP  = 2'b10,   // first cycle after a stop, no drive
        ST_MINON = 2'b11    // second cycle after a stop, minimum pulse
    } agdl_state_e;

    // ------------------------------------------------------------------
    // low-supply cap on the drive high level
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LIM_NONE   = 2'b00, // step value alone
        LIM_SUPPLY = 2'b01, // min of step and supply
        LIM_DROP   = 2'b10  // min of step and supply less 1.2 V
    } agdl_limit_e;

endpackage

// File: verif/adaptive_gate_drive_level_test.sv
// self-checking bench of the adaptive gate-drive level block
`timescale 1ns/1ps
`default_nettype none

module adaptive_gate_drive_level_test;
    // ------------------------------------------------------------
    // settings and signals
    // ------------------------------------------------------------
    localparam int MIN_ON  = 60;     // minimum on-time in clocks
    localparam int IDLE    = 20;     // drain-high clocks per cycle
    localparam int CEILING = 60000;  // cycle limit of the run

    logic                  clk_in;
    logic                  sys_rst_in;
    logic                  drain_sense_in;
    logic                  supply_above_en_in;
    logic                  supply_below_dis_in;
    logic                  supply_low_in;
    logic                  aux_supply_pin_in;
    logic [9:0]            min_on_cyc_in;
    logic                  gate_drive_out;
    logic [3:0]            drive_level_step_out;
    agdl_pkg::agdl_limit_e drive_limit_out;
    logic                  sleep_mode_out;
    logic                  burst_mode_out;
    int                    mismatches;
    int                    samples_checked;
    int                    cycles;

    // one row: stimulus beside the outputs it should give
    typedef struct {
        int                    td;
        int                    n;
        logic [3:0]            pins;  // en, dis, low, aux
        logic                  chk_lvl;
        logic [3:0]            lvl;
        agdl_pkg::agdl_limit_e lim;
        logic                  slp;
    } agdl_row_s;

    agdl_row_s rows [10] = '{
        '{97, 1,  4'h8, 1'b1, 4'h0, agdl_pkg::LIM_NONE,   1'b0},  // sleep exit
        '{97, 32, 4'h8, 1'b1, 4'h1, agdl_pkg::LIM_NONE,   1'b0},  // climb one
        '{97, 2,  4'ha, 1'b1, 4'h1, agdl_pkg::LIM_DROP,   1'b0},  // low, no aux: drop
        '{97, 2,  4'hb, 1'b1, 4'h1, agdl_pkg::LIM_SUPPLY, 1'b0},  // aux in use
        '{97, 2,  4'h6, 1'b1, 4'hf, agdl_pkg::LIM_NONE,   1'b0},  // disabled
        '{97, 2,  4'h0, 1'b1, 4'hf, agdl_pkg::LIM_NONE,   1'b0},  // hysteresis
        '{60, 1,  4'h8, 1'b0, 4'h0, agdl_pkg::LIM_NONE,   1'b1},  // sleep entry
        '{97, 1,  4'h8, 1'b1, 4'h0, agdl_pkg::LIM_NONE,   1'b0},  // restart low
        '{97, 30, 4'h8, 1'b1, 4'h0, agdl_pkg::LIM_NONE,   1'b0},  // not yet
        '{97, 2,  4'h8, 1'b1, 4'h1, agdl_pkg::LIM_NONE,   1'b0}   // climbs
    };

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    agdl_top agdl_top_i (
        .clk_in               (clk_in),
        .sys_rst_in           (sys_rst_in),
        .drain_sense_in       (drain_sense_in),
        .supply_above_en_in   (supply_above_en_in),
        .supply_below_dis_in  (supply_below_dis_in),
        .supply_low_in        (supply_low_in),
        .aux_supply_pin_in    (aux_supply_pin_in),
        .min_on_cyc_in        (min_on_cyc_in),
        .gate_drive_out       (gate_drive_out),
        .drive_level_step_out (drive_level_step_out),
        .drive_limit_out      (drive_limit_out),
        .sleep_mode_out       (sleep_mode_out),
        .burst_mode_out       (burst_mode_out)
    );

    agdl_sr_fet agdl_sr_fet_i (
        .clk_in    (clk_in),
        .gate_in   (gate_drive_out),
        .drain_out (drain_sense_in)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // a run past the ceiling counts as a mismatch
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // several switching cycles of one demagnetization time
    task automatic run_cycles(input int td, input int n);
        repeat (n) agdl_sr_fet_i.switch_cycle(td, IDLE);
    endtask

    // outputs held while reset is applied
    task automatic check_reset_state();
        check("reset gate", {31'h0, gate_drive_out}, 32'h0);
        check("reset level", {28'h0, drive_level_step_out}, 32'hf);
        check("reset limit", {30'h0, drive_limit_out}, 32'h0);
        check("reset sleep", {31'h0, sleep_mode_out}, 32'h1);
        check("reset burst", {31'h0, burst_mode_out}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst_in = 1'b1;
        supply_above_en_in = 1'b1;
        supply_below_dis_in = 1'b0;
        supply_low_in = 1'b0;
        aux_supply_pin_in = 1'b0;
        min_on_cyc_in = 10'(MIN_ON);
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (10) @(posedge clk_in);
        #2;
        check_reset_state();
        sys_rst_in = 1'b0;
        // outputs still at reset values two edges after release
        repeat (2) @(posedge clk_in);
        #2;
        check_reset_state();
        repeat (2) @(posedge clk_in);
        #2;
        // table of ordinary cases
        foreach (rows[i]) begin
            {supply_above_en_in, supply_below_dis_in, supply_low_in, aux_supply_pin_in} =
                rows[i].pins;
            run_cycles(rows[i].td, rows[i].n);
            if (rows[i].chk_lvl) begin
                check("row level", {28'h0, drive_level_step_out}, {28'h0, rows[i].lvl});
            end
            check("row limit", {30'h0, drive_limit_out}, {30'h0, rows[i].lim});
            check("row sleep", {31'h0, sleep_mode_out}, {31'h0, rows[i].slp});
            $display("test row %0d done", i);
        end
        // long conduction is cut at the maximum on-time
        run_cycles(1000, 1);
        check("max on", {31'h0, agdl_sr_fet_i.gate_cycles inside {[790:801]}}, 32'h1);
        $display("test max on-time done");
        // switching stop, skipped cycle, minimum pulse, top level
        repeat (1700) @(posedge clk_in);
        #2;
        check("burst seen", {31'h0, burst_mode_out}, 32'h1);
        check("burst top", {28'h0, drive_level_step_out}, 32'hf);
        run_cycles(97, 1);
        check("skip gate", agdl_sr_fet_i.gate_cycles, 32'h0);
        check("burst clear", {31'h0, burst_mode_out}, 32'h0);
        run_cycles(300, 1);
        check("min pulse", {31'h0, agdl_sr_fet_i.gate_cycles inside {[59:61]}}, 32'h1);
        check("burst level", {28'h0, drive_level_step_out}, 32'hf);
        $display("test burst resume done");
        // top band held at the top step
        run_cycles(250, 40);
        check("top hold", {28'h0, drive_level_step_out}, 32'hf);
        // shorter demagnetization lowers one step after 32 cycles
        run_cycles(97, 30);
        check("down early", {28'h0, drive_level_step_out}, 32'hf);
        run_cycles(97, 2);
        check("down one", {28'h0, drive_level_step_out}, 32'he);
        $display("test saturate and lower done");
        // second reset in mid-run
        sys_rst_in = 1'b1;
        repeat (10) @(posedge clk_in);
        #2;
        check_reset_state();
        sys_rst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #2;
        check_reset_state();
        // supply already above enable: adaptation returns at the low step
        repeat (6) @(posedge clk_in);
        #2;
        check("restart level", {28'h0, drive_level_step_out}, 32'h0);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule

`default_nettype wire

// File: verif/agdl_sr_fet.sv
// drain sense model of the external rectifier switch
`timescale 1ns/1ps
`default_nettype none

module agdl_sr_fet (
    input  wire logic clk_in,    // controller clock
    input  wire logic gate_in,   // gate drive from the controller
    output var logic  drain_out  // high: drain above threshold
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    int gate_cycles;  // gate-high clocks in the last switching cycle

    initial begin
        drain_out = 1'b1;
        gate_cycles = 0;
    end

    // count gate-high clocks of the running cycle
    always @(posedge clk_in) begin
        if (gate_in === 1'b1) begin
            gate_cycles <= gate_cycles + 1;
        end
    end

    // ------------------------------------------------------------
    // one switching cycle: body conduction, then drain back high
    // ------------------------------------------------------------
    // entered 2 ns after an edge, returns 2 ns after an edge
    task automatic switch_cycle(input int td, input int idle);
        gate_cycles = 0;
        drain_out = 1'b0;
        repeat (td) @(posedge clk_in);
        #2;
        drain_out = 1'b1;
        repeat (idle) @(posedge clk_in);
        #2;
    endtask
endmodule

`default_nettype wire
